/* File: shared/pssw_consts.svh */
`ifndef PSSW_CONSTS_SVH
`define PSSW_CONSTS_SVH
// Clock rate in kHz, one tick of the time base
`define PSSW_CLK_KHZ 100000
// Watchdog default after factory initialisation, in ms
`define PSSW_WDOG_DEFAULT_MS 200
// Watchdog default in cycles, derived from time and rate
`define PSSW_WDOG_DEFAULT_CYC (`PSSW_WDOG_DEFAULT_MS * `PSSW_CLK_KHZ)
// Loop count of the larger and the smaller variant
`define PSSW_LOOPS_LARGE 16
`define PSSW_LOOPS_SMALL 4
// Software timeout error code
`define PSSW_ERR_TIMEOUT 16'h0003
`define PSSW_ERR_NONE 16'h0000
`endif

/* File: shared/pssw_pkg.sv */
package pssw_pkg;
    // Scan segments
    typedef enum logic [2:0] {
        PSSW_IDLE,
        PSSW_SOLVE,
        PSSW_LOOPS,
        PSSW_WR_LOCAL,
        PSSW_WR_REMOTE,
        PSSW_DIAG
    } pssw_seg_t;
    // Instruction opcodes seen on the program fetch port
    typedef enum logic [2:0] {
        PSSW_OP_NOP,
        PSSW_OP_OUT,
        PSSW_OP_RELAY,
        PSSW_OP_IMM_RD,
        PSSW_OP_IMM_WR,
        PSSW_OP_WDOG_RESTART,
        PSSW_OP_END
    } pssw_op_t;
endpackage

/* File: src/pssw_loop_sched.sv */
`timescale 1ns/10ps
// Per-loop sample interval scheduler
module pssw_loop_sched #(
    parameter int LOOPS = 16,
    parameter int IW = 16
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Configuration
    input wire logic [LOOPS-1:0] loop_cfg_in,
    input wire logic [LOOPS*IW-1:0] loop_interval_in,
    // One pulse per scan at loop segment start
    input wire logic scan_tick_in,
    // Loops due this scan
    output logic [LOOPS-1:0] loop_due_out
);
    genvar g;
    generate
        for (g = 0; g < LOOPS; g++) begin : g_loop
            logic [IW-1:0] cnt_reg; // Scans since last calculation
            logic due_reg;
            // Count scans; due once interval reached, only when configured
            always_ff @(posedge core_clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    cnt_reg <= '0;
                    due_reg <= 1'b0;
                end else if (scan_tick_in) begin
                    if (loop_cfg_in[g] && cnt_reg + 1'b1 >= loop_interval_in[g*IW +: IW]) begin
                        cnt_reg <= '0;
                        due_reg <= 1'b1;
                    end else begin
                        cnt_reg <= loop_cfg_in[g] ? cnt_reg + 1'b1 : '0;
                        due_reg <= 1'b0;
                    end
                end
            end
            assign loop_due_out[g] = due_reg;
        end
    endgenerate
endmodule

/* File: src/pssw_scan_stats.sv */
`timescale 1ns/10ps
// Scan time measurement: current, minimum and maximum
module pssw_scan_stats #(
    parameter int TW = 32
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Control
    input wire logic run_start_in,
    input wire logic scan_end_in,
    // Results
    output logic [TW-1:0] scan_cur_out,
    output logic [TW-1:0] scan_min_out,
    output logic [TW-1:0] scan_max_out
);
    logic [TW-1:0] cnt_reg; // Running scan length
    logic first_reg; // No scan finished since run entry
    // Measure and keep extremes since the last entry into run
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_reg <= '0;
            first_reg <= 1'b1;
            scan_cur_out <= '0;
            scan_min_out <= '0;
            scan_max_out <= '0;
        end else if (run_start_in) begin
            cnt_reg <= '0;
            first_reg <= 1'b1;
            scan_min_out <= '0;
            scan_max_out <= '0;
        end else if (scan_end_in) begin
            cnt_reg <= '0;
            first_reg <= 1'b0;
            scan_cur_out <= cnt_reg + 1'b1;
            if (first_reg || cnt_reg + 1'b1 < scan_min_out) begin
                scan_min_out <= cnt_reg + 1'b1;
            end
            if (first_reg || cnt_reg + 1'b1 > scan_max_out) begin
                scan_max_out <= cnt_reg + 1'b1;
            end
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule

/* File: src/pssw_scan_seq.sv */
`timescale 1ns/10ps
`include "pssw_consts.svh"
// Functional notes
// - Solve from first rung, in order
// - End instruction completes the output image
// - Update relays, stages and words while solving
// - Logic result overwrites a forced output
// - Undriven forced output keeps forced value
// - Loop calculations follow solving, 16 or 4
// - Only configured loops, when interval due
// - Copy image with forces to local outputs
// - Then send outputs to specialty and remote
// - Diagnostics: scan time, special relays, watchdog
// - Watchdog limit, default 200 ms
// - Timeout: program mode, outputs off, E003
// - Adjustable limit, scan time statistics visible
// - Restart instruction rearms the watchdog
// - Early input change: one scan response
// - Late input change: two scans response
// - Immediate path: only instruction time added
// - Immediate read bypasses the input image
// - Outputs only in run; program holds off
// - Fatal error forces program, outputs off
module pssw_scan_seq #(
    parameter int NPTS = 16,
    parameter int NREL = 16,
    parameter int AW = 10,
    parameter int LOOPS = `PSSW_LOOPS_LARGE,
    parameter int IW = 16,
    parameter int TW = 32,
    parameter logic [TW-1:0] WDOG_DEFAULT = TW'(`PSSW_WDOG_DEFAULT_CYC)
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Mode control
    input wire logic run_req_in,
    input wire logic fatal_err_in,
    // Program fetch: op, operand index, condition result
    output logic [AW-1:0] pc_out,
    input wire logic [2:0] op_in,
    input wire logic [7:0] operand_in,
    input wire logic cond_in,
    // Input image and immediate module read
    input wire logic [NPTS-1:0] in_image_in,
    input wire logic [NPTS-1:0] in_module_in,
    output logic imm_bit_out,
    // Forces from peripheral service
    input wire logic [NPTS-1:0] force_mask_in,
    input wire logic [NPTS-1:0] force_val_in,
    // Loop configuration and handshake
    input wire logic [LOOPS-1:0] loop_cfg_in,
    input wire logic [LOOPS*IW-1:0] loop_interval_in,
    output logic [LOOPS-1:0] loop_start_out,
    input wire logic loop_done_in,
    // Watchdog limit
    input wire logic wdog_load_in,
    input wire logic [TW-1:0] wdog_limit_in,
    // Outputs
    output logic [NPTS-1:0] local_out,
    output logic local_wr_out,
    output logic [NPTS-1:0] remote_out,
    output logic remote_wr_out,
    output logic [NREL-1:0] relay_out,
    output logic [7:0] imm_wr_out,
    // Status
    output logic run_mode_out,
    output logic [15:0] err_code_out,
    output logic diag_pulse_out,
    output logic [TW-1:0] scan_cur_out,
    output logic [TW-1:0] scan_min_out,
    output logic [TW-1:0] scan_max_out
);
    pssw_pkg::pssw_seg_t seg_reg; // Current segment
    logic [NPTS-1:0] img_reg; // Output image
    logic [NREL-1:0] rel_reg; // Control relays/stages
    logic [TW-1:0] wd_cnt_reg; // Watchdog count
    logic [TW-1:0] wd_lim_reg; // Watchdog limit
    logic run_reg; // Run mode flag
    logic run_q_reg; // Previous run flag
    logic wd_trip; // Watchdog overrun
    logic [LOOPS-1:0] loop_due;
    logic [NPTS-1:0] idx_sel; // One-hot point of operand
    logic loop_issued_reg; // Start already sent this scan
    pssw_pkg::pssw_op_t op;

    assign op = pssw_pkg::pssw_op_t'(op_in);
    assign idx_sel = NPTS'(1) << operand_in;
    assign wd_trip = (seg_reg == pssw_pkg::PSSW_SOLVE) && (wd_cnt_reg >= wd_lim_reg);
    assign run_mode_out = run_reg;
    assign relay_out = rel_reg;

    // Loop scheduler ticks once per scan as loops begin
    pssw_loop_sched #(.LOOPS(LOOPS), .IW(IW)) u_sched (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .loop_cfg_in(loop_cfg_in),
        .loop_interval_in(loop_interval_in),
        .scan_tick_in(seg_reg == pssw_pkg::PSSW_SOLVE && op == pssw_pkg::PSSW_OP_END),
        .loop_due_out(loop_due)
    );

    // Scan time statistics since the last entry into run
    pssw_scan_stats #(.TW(TW)) u_stats (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .run_start_in(run_reg && !run_q_reg),
        .scan_end_in(seg_reg == pssw_pkg::PSSW_DIAG),
        .scan_cur_out(scan_cur_out),
        .scan_min_out(scan_min_out),
        .scan_max_out(scan_max_out)
    );

    // Mode: fatal error or watchdog overrun drops to program
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            run_reg <= 1'b0;
            run_q_reg <= 1'b0;
            err_code_out <= `PSSW_ERR_NONE;
        end else begin
            run_q_reg <= run_reg;
            if (wd_trip) begin
                run_reg <= 1'b0;
                err_code_out <= `PSSW_ERR_TIMEOUT;
            end else if (fatal_err_in) begin
                run_reg <= 1'b0;
            end else if (!run_reg && run_req_in) begin
                run_reg <= 1'b1;
                err_code_out <= `PSSW_ERR_NONE;
            end else if (!run_req_in) begin
                run_reg <= 1'b0;
            end
        end
    end

    // Segment sequencer
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seg_reg <= pssw_pkg::PSSW_IDLE;
            pc_out <= '0;
        end else if (!run_reg || wd_trip || fatal_err_in) begin
            seg_reg <= pssw_pkg::PSSW_IDLE;
            pc_out <= '0;
        end else begin
            case (seg_reg)
                pssw_pkg::PSSW_IDLE: begin
                    seg_reg <= pssw_pkg::PSSW_SOLVE;
                    pc_out <= '0;
                end
                pssw_pkg::PSSW_SOLVE: begin
                    if (op == pssw_pkg::PSSW_OP_END) begin
                        seg_reg <= pssw_pkg::PSSW_LOOPS;
                    end else begin
                        pc_out <= pc_out + 1'b1;
                    end
                end
                pssw_pkg::PSSW_LOOPS: begin
                    // Wait for loop engine unless nothing was due
                    if ((loop_due & loop_cfg_in) == '0 || loop_done_in) begin
                        seg_reg <= pssw_pkg::PSSW_WR_LOCAL;
                    end
                end
                pssw_pkg::PSSW_WR_LOCAL: begin
                    seg_reg <= pssw_pkg::PSSW_WR_REMOTE;
                end
                pssw_pkg::PSSW_WR_REMOTE: begin
                    seg_reg <= pssw_pkg::PSSW_DIAG;
                end
                default: begin
                    // Next scan reads fresh image, hence one or two scans latency
                    seg_reg <= pssw_pkg::PSSW_SOLVE;
                    pc_out <= '0;
                end
            endcase
        end
    end

    // Output image and relay update while solving
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            img_reg <= '0;
            rel_reg <= '0;
        end else if (seg_reg == pssw_pkg::PSSW_IDLE) begin
            // Forces land in image before solve; driven points overwrite later
            img_reg <= (img_reg & ~force_mask_in) | (force_val_in & force_mask_in);
        end else if (seg_reg == pssw_pkg::PSSW_DIAG) begin
            img_reg <= (img_reg & ~force_mask_in) | (force_val_in & force_mask_in);
        end else if (seg_reg == pssw_pkg::PSSW_SOLVE) begin
            if (op == pssw_pkg::PSSW_OP_OUT) begin
                img_reg <= cond_in ? (img_reg | idx_sel) : (img_reg & ~idx_sel);
            end else if (op == pssw_pkg::PSSW_OP_RELAY) begin
                rel_reg[operand_in[$clog2(NREL)-1:0]] <= cond_in;
            end
        end
    end

    // Immediate read uses module; an output rung loads imm_bit_out from the input image
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            imm_bit_out <= 1'b0;
            imm_wr_out <= 8'h00;
        end else if (seg_reg == pssw_pkg::PSSW_SOLVE && op == pssw_pkg::PSSW_OP_IMM_RD) begin
            imm_bit_out <= |(in_module_in & idx_sel);
        end else if (seg_reg == pssw_pkg::PSSW_SOLVE && op == pssw_pkg::PSSW_OP_OUT) begin
            imm_bit_out <= |(in_image_in & idx_sel);
        end else if (seg_reg == pssw_pkg::PSSW_SOLVE && op == pssw_pkg::PSSW_OP_IMM_WR) begin
            imm_wr_out <= operand_in;
        end
    end

    // Loop start strobes only for configured and due loops
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            loop_start_out <= '0;
            loop_issued_reg <= 1'b0;
        end else if (seg_reg != pssw_pkg::PSSW_LOOPS) begin
            loop_start_out <= '0;
            loop_issued_reg <= 1'b0;
        end else begin
            // One strobe per scan; a repeat would restart the loop engine forever
            loop_start_out <= loop_issued_reg ? '0 : (loop_due & loop_cfg_in);
            loop_issued_reg <= 1'b1;
        end
    end

    // Output writes; off in program mode
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            local_out <= '0;
            remote_out <= '0;
            local_wr_out <= 1'b0;
            remote_wr_out <= 1'b0;
        end else if (!run_reg || wd_trip || fatal_err_in) begin
            local_out <= '0;
            remote_out <= '0;
            local_wr_out <= 1'b0;
            remote_wr_out <= 1'b0;
        end else begin
            local_wr_out <= seg_reg == pssw_pkg::PSSW_WR_LOCAL;
            remote_wr_out <= seg_reg == pssw_pkg::PSSW_WR_REMOTE;
            if (seg_reg == pssw_pkg::PSSW_WR_LOCAL) begin
                local_out <= img_reg;
            end
            if (seg_reg == pssw_pkg::PSSW_WR_REMOTE) begin
                remote_out <= img_reg;
            end
        end
    end

    // Watchdog limit, operator adjustable
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wd_lim_reg <= WDOG_DEFAULT;
        end else if (wdog_load_in) begin
            wd_lim_reg <= wdog_limit_in;
        end
    end

    // Watchdog counter over the solve segment
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wd_cnt_reg <= '0;
            diag_pulse_out <= 1'b0;
        end else begin
            diag_pulse_out <= seg_reg == pssw_pkg::PSSW_DIAG;
            if (seg_reg == pssw_pkg::PSSW_DIAG || seg_reg == pssw_pkg::PSSW_IDLE) begin
                wd_cnt_reg <= '0;
            end else if (seg_reg == pssw_pkg::PSSW_SOLVE && op == pssw_pkg::PSSW_OP_WDOG_RESTART) begin
                wd_cnt_reg <= '0;
            end else if (seg_reg == pssw_pkg::PSSW_SOLVE) begin
                wd_cnt_reg <= wd_cnt_reg + 1'b1;
            end
        end
    end

    // Assertions
    a_trip_program: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        wd_trip |=> !run_mode_out && err_code_out == `PSSW_ERR_TIMEOUT) else $error("timeout kept run");
    a_prog_outs_off: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !run_reg |=> local_out == '0 && !local_wr_out) else $error("outputs on in program");
    a_local_first: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        remote_wr_out |-> $past(local_wr_out)) else $error("remote before local");
    a_end_to_loops: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        seg_reg == pssw_pkg::PSSW_SOLVE && op == pssw_pkg::PSSW_OP_END && run_reg && !fatal_err_in && !wd_trip
        |=> seg_reg == pssw_pkg::PSSW_LOOPS) else $error("end not honoured");
    a_restart_clear: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        seg_reg == pssw_pkg::PSSW_SOLVE && op == pssw_pkg::PSSW_OP_WDOG_RESTART |=> wd_cnt_reg == '0)
        else $error("restart ignored");
    a_diag_clear: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        seg_reg == pssw_pkg::PSSW_DIAG |=> wd_cnt_reg == '0 && diag_pulse_out) else $error("diag no clear");
    a_loop_cfg_only: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (loop_start_out & ~loop_cfg_in) == '0 || $past(loop_cfg_in) != loop_cfg_in)
        else $error("unconfigured loop run");
    a_local_image: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        local_wr_out |-> local_out == $past(img_reg)) else $error("local not image");
    a_fatal_program: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        fatal_err_in |=> !run_mode_out) else $error("fatal kept run");
endmodule

/* File: bench/pssw_far_model.sv */
`timescale 1ns/10ps
// Far side: program store, loop calculator and remote-link master
module pssw_far_model #(
    parameter int AW = 10,
    parameter int LOOPS = 4,
    parameter int NPTS = 16,
    parameter int DLY = 3
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Program fetch
    input wire logic [AW-1:0] pc_in,
    output logic [2:0] op_out,
    output logic [7:0] operand_out,
    output logic cond_out,
    // Loop handshake
    input wire logic [LOOPS-1:0] loop_start_in,
    output logic loop_done_out,
    // Remote data from the sequencer
    input wire logic [NPTS-1:0] remote_in,
    input wire logic remote_wr_in,
    output logic [NPTS-1:0] remote_applied_out
);
    // Program store, filled by the bench
    logic [2:0] prog_op [0:127];
    logic [7:0] prog_opd [0:127];
    logic prog_cond [0:127];
    int busy_cnt; // Loop calculation countdown
    logic [NPTS-1:0] pend_reg; // Data held for the next exchange
    int exch_cnt; // Link exchange period
    // Fetch answers in the same cycle; past the store it ends the program
    always_comb begin
        if (int'(pc_in) < 128) begin
            op_out = prog_op[pc_in];
            operand_out = prog_opd[pc_in];
            cond_out = prog_cond[pc_in];
        end else begin
            op_out = 3'(pssw_pkg::PSSW_OP_END);
            operand_out = 8'h00;
            cond_out = 1'b0;
        end
    end
    // Slow loop calculator: done pulse some cycles after a start
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_cnt <= 0;
            loop_done_out <= 1'b0;
        end else begin
            if (|loop_start_in) begin
                busy_cnt <= DLY;
            end else if (busy_cnt > 0) begin
                busy_cnt <= busy_cnt - 1;
            end
            loop_done_out <= (busy_cnt == 1);
        end
    end
    // Master takes data every scan, applies it on its own exchange only
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pend_reg <= '0;
            exch_cnt <= 0;
            remote_applied_out <= '0;
        end else begin
            if (remote_wr_in) begin
                pend_reg <= remote_in;
            end
            exch_cnt <= (exch_cnt == 7) ? 0 : exch_cnt + 1;
            if (exch_cnt == 7) begin
                remote_applied_out <= pend_reg;
            end
        end
    end
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/10ps
// Self-checking bench for the scan sequencer
module testbench;
    typedef struct {logic [7:0] pt; logic c; logic [15:0] fm; logic [15:0] fv; logic [15:0] ex;} pssw_row_t;
    logic core_clk_in = 1'b0; // Clock
    logic arst_n_in = 1'b0; // Reset, held at start
    logic run_req_in = 1'b0;
    logic fatal_err_in = 1'b0;
    logic [9:0] pc_out;
    logic [2:0] op_in;
    logic [7:0] operand_in;
    logic cond_in;
    logic [15:0] in_image_in = 16'h0000;
    logic [15:0] in_module_in = 16'h0000;
    logic imm_bit_out;
    logic [15:0] force_mask_in = 16'h0000;
    logic [15:0] force_val_in = 16'h0000;
    logic [3:0] loop_cfg_in = 4'h0;
    logic [63:0] loop_interval_in = 64'h0001_0001_0001_0001; // Every scan
    logic [3:0] loop_start_out;
    logic loop_done_in;
    logic wdog_load_in = 1'b0;
    logic [31:0] wdog_limit_in = 32'h0000_0000;
    logic [15:0] local_out, remote_out, relay_out, remote_applied;
    logic local_wr_out, remote_wr_out, run_mode_out, diag_pulse_out;
    logic [7:0] imm_wr_out;
    logic [15:0] err_code_out;
    logic [31:0] scan_cur_out, scan_min_out, scan_max_out;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0; // Cycle stamp for ordering
    int n_start [4]; // Loop starts seen per loop
    int t0, tl, tr, td; // Event stamps
    pssw_row_t rows [5];
    // 100 MHz clock
    always #5 core_clk_in = ~core_clk_in;
    // Cycle stamp and loop start census
    always @(posedge core_clk_in) begin
        cyc++;
        for (int k = 0; k < 4; k++) begin
            if (loop_start_out[k] === 1'b1) n_start[k]++;
        end
    end
    // Small watchdog limit so a timeout takes tens of cycles
    pssw_scan_seq #(.LOOPS(4), .WDOG_DEFAULT(32'h0000_0032)) DUT (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .run_req_in(run_req_in),
        .fatal_err_in(fatal_err_in), .pc_out(pc_out), .op_in(op_in), .operand_in(operand_in),
        .cond_in(cond_in), .in_image_in(in_image_in), .in_module_in(in_module_in),
        .imm_bit_out(imm_bit_out), .force_mask_in(force_mask_in), .force_val_in(force_val_in),
        .loop_cfg_in(loop_cfg_in), .loop_interval_in(loop_interval_in),
        .loop_start_out(loop_start_out), .loop_done_in(loop_done_in),
        .wdog_load_in(wdog_load_in), .wdog_limit_in(wdog_limit_in), .local_out(local_out),
        .local_wr_out(local_wr_out), .remote_out(remote_out), .remote_wr_out(remote_wr_out),
        .relay_out(relay_out), .imm_wr_out(imm_wr_out), .run_mode_out(run_mode_out),
        .err_code_out(err_code_out), .diag_pulse_out(diag_pulse_out), .scan_cur_out(scan_cur_out),
        .scan_min_out(scan_min_out), .scan_max_out(scan_max_out));
    // Program store and the rest of the far side
    pssw_far_model #(.AW(10), .LOOPS(4), .NPTS(16), .DLY(3)) FAR (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .pc_in(pc_out), .op_out(op_in),
        .operand_out(operand_in), .cond_out(cond_in), .loop_start_in(loop_start_out),
        .loop_done_out(loop_done_in), .remote_in(remote_out), .remote_wr_in(remote_wr_out),
        .remote_applied_out(remote_applied));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] ex);
        n_checks++;
        if (got !== ex) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask
    // Write one program slot
    task automatic put(input int i, input logic [2:0] op, input logic [7:0] opd, input logic c);
        FAR.prog_op[i] = op;
        FAR.prog_opd[i] = opd;
        FAR.prog_cond[i] = c;
    endtask
    // Reset for two cycles with an empty program
    task automatic do_reset();
        @(negedge core_clk_in);
        arst_n_in = 1'b0;
        run_req_in = 1'b0;
        for (int i = 0; i < 128; i++) put(i, 3'(pssw_pkg::PSSW_OP_END), 8'h00, 1'b0);
        repeat (2) @(negedge core_clk_in);
        arst_n_in = 1'b1;
    endtask
    // Bounded wait: 0 local write, 1 remote write, 2 diag, 3 timeout code
    task automatic wait_ev(input int which, output int at);
        logic hit;
        at = -1;
        for (int i = 0; i < 400 && at < 0; i++) begin
            @(negedge core_clk_in);
            case (which)
                0: hit = local_wr_out;
                1: hit = remote_wr_out;
                2: hit = diag_pulse_out;
                default: hit = (err_code_out === 16'h0003);
            endcase
            if (hit === 1'b1) at = cyc;
        end
        if (at < 0) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, which, 1);
        end
    endtask
    // One scan: local write, then remote write, then diagnostics
    task automatic scan_order();
        wait_ev(0, tl);
        wait_ev(1, tr);
        chk(tr > tl, 1);
        wait_ev(2, td);
        chk(td > tr, 1);
    endtask
    // Ends the run in one place
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, far beyond the expected run length
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
    initial begin
        rows[0] = '{8'h00, 1'b1, 16'h0000, 16'h0000, 16'h0001};
        rows[1] = '{8'h0f, 1'b1, 16'h0000, 16'h0000, 16'h8000};
        rows[2] = '{8'h03, 1'b0, 16'h0008, 16'h0008, 16'h0000};
        rows[3] = '{8'h03, 1'b1, 16'h0100, 16'h0100, 16'h0108};
        rows[4] = '{8'h05, 1'b0, 16'h00f0, 16'h00a0, 16'h0080};
        repeat (2) @(negedge core_clk_in);
        chk(run_mode_out, 0);
        chk(local_out, 0);
        // Ordinary cases: one output rung, with and without forces
        for (int r = 0; r < 5; r++) begin
            do_reset();
            force_mask_in = rows[r].fm;
            force_val_in = rows[r].fv;
            put(0, 3'(pssw_pkg::PSSW_OP_OUT), rows[r].pt, rows[r].c);
            run_req_in = 1'b1;
            scan_order();
            chk(local_out, rows[r].ex);
            chk(remote_out, rows[r].ex);
            repeat (8) @(negedge core_clk_in);
            chk(remote_applied, rows[r].ex);
        end
        force_mask_in = 16'h0000;
        // Rung order, relays, nothing after the end instruction
        do_reset();
        put(0, 3'(pssw_pkg::PSSW_OP_OUT), 8'h02, 1'b1);
        put(1, 3'(pssw_pkg::PSSW_OP_OUT), 8'h02, 1'b0);
        put(2, 3'(pssw_pkg::PSSW_OP_RELAY), 8'h04, 1'b1);
        put(4, 3'(pssw_pkg::PSSW_OP_OUT), 8'h09, 1'b1);
        run_req_in = 1'b1;
        scan_order();
        chk(local_out, 0);
        chk(relay_out, 16'h0010);
        scan_order();
        chk(scan_cur_out != 0 && scan_min_out != 0, 1);
        chk(scan_min_out <= scan_max_out, 1);
        // Fatal error mid-run
        fatal_err_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        chk(run_mode_out, 0);
        chk(local_out | remote_out, 0);
        fatal_err_in = 1'b0;
        // Immediate read and write, module read again on a later scan
        do_reset();
        in_module_in = 16'h0004;
        put(0, 3'(pssw_pkg::PSSW_OP_IMM_RD), 8'h02, 1'b0);
        put(1, 3'(pssw_pkg::PSSW_OP_IMM_WR), 8'h5a, 1'b0);
        run_req_in = 1'b1;
        scan_order();
        chk(imm_bit_out, 1);
        chk(imm_wr_out, 8'h5a);
        in_module_in = 16'h0000;
        in_image_in = 16'h0004; // Image must not feed an immediate read
        scan_order();
        chk(imm_bit_out, 0);
        // Only the configured loop is calculated
        do_reset();
        loop_cfg_in = 4'h2;
        loop_interval_in = 64'h0001_0001_0002_0001; // Loop 1 every second scan
        for (int k = 0; k < 4; k++) n_start[k] = 0;
        run_req_in = 1'b1;
        repeat (3) scan_order();
        chk(n_start[1], 1);
        chk(n_start[0] + n_start[2] + n_start[3], 0);
        loop_cfg_in = 4'h0;
        // Default limit overrun
        do_reset();
        for (int i = 0; i < 60; i++) put(i, 3'(pssw_pkg::PSSW_OP_NOP), 8'h00, 1'b0);
        run_req_in = 1'b1;
        t0 = cyc;
        wait_ev(3, td);
        chk(td - t0 >= 50, 1);
        chk(run_mode_out, 0);
        chk(local_out, 0);
        // Restart instruction halfway keeps a long program alive
        do_reset();
        for (int i = 0; i < 80; i++) put(i, 3'(pssw_pkg::PSSW_OP_NOP), 8'h00, 1'b0);
        put(40, 3'(pssw_pkg::PSSW_OP_WDOG_RESTART), 8'h00, 1'b0);
        run_req_in = 1'b1;
        scan_order();
        chk(err_code_out, 0);
        chk(run_mode_out, 1);
        // Lowered limit trips a shorter program
        do_reset();
        wdog_limit_in = 32'h0000_0014;
        wdog_load_in = 1'b1;
        @(negedge core_clk_in);
        wdog_load_in = 1'b0;
        for (int i = 0; i < 30; i++) put(i, 3'(pssw_pkg::PSSW_OP_NOP), 8'h00, 1'b0);
        run_req_in = 1'b1;
        t0 = cyc;
        wait_ev(3, td);
        chk(td - t0 < 50, 1);
        conclude();
    end
endmodule
